//--- logic/swm_bit_timer.sv
`timescale 1ns/100ps
module swm_bit_timer #(
	parameter int DIV = swm_pkg::BIT_CYC
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic run,
	output logic tick
);
	localparam int CW = $clog2(DIV + 1);
	logic [CW-1:0] cnt_reg;
	// Tick decoded from the count, so the first bit is as long as the rest
	assign tick = run && (cnt_reg == CW'(DIV - 1));
	// Restarts when idle so every bit period is full length
	always_ff @(posedge mclk) begin
		if (!rst_n || !run)
			cnt_reg <= '0;
		else if (tick)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_reg + 1'b1;
	end
endmodule : swm_bit_timer

//--- logic/swm_master.sv
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
module swm_master (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	output logic irq,
	input wire logic linkPin_i,
	output logic linkPin_o,
	output logic linkPin_oe,
	input wire logic bypassRx_i,
	output logic bypassRx_o,
	output logic bypassRx_oe,
	output logic stopBlock
);
	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	logic ctrl_reg;
	logic [1:0] opt_reg;
	logic [swm_pkg::ST_W-1:0] stat_reg;
	logic [swm_pkg::ST_W-1:0] mask_reg;
	swm_pkg::swm_state_t state_reg;
	swm_pkg::swm_evt_t evt;
	logic [4:0] bitCnt_reg;
	logic pinSync1_reg;
	logic pinSync2_reg;
	logic pinPrev_reg;
	logic tick;
	logic req;
	logic wr;
	logic [3:0] adr;

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Writes land on the edge at which the master samples ack high
	assign wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
	assign adr = wb_adr_i[3:0];

	function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
		hit = (a == r) && (wb_adr_i[31:4] == 28'h0000000);
	endfunction : hit

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= 32'h00000000;
			if (req && !wb_we_i) begin
				if (hit(adr, swm_pkg::ADDR_CTRL))
					wb_dat_o[swm_pkg::CTRL_EN] <= ctrl_reg;
				else if (hit(adr, swm_pkg::ADDR_STAT))
					wb_dat_o[swm_pkg::ST_W-1:0] <= stat_reg;
				else if (hit(adr, swm_pkg::ADDR_MASK))
					wb_dat_o[swm_pkg::ST_W-1:0] <= mask_reg;
				else if (hit(adr, swm_pkg::ADDR_OPT))
					wb_dat_o[1:0] <= opt_reg;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctrl_reg <= 1'b0;
			opt_reg <= 2'h0;
			mask_reg <= '0;
		end else if (wr) begin
			if (hit(adr, swm_pkg::ADDR_CTRL))
				ctrl_reg <= wb_dat_i[swm_pkg::CTRL_EN];
			if (hit(adr, swm_pkg::ADDR_OPT))
				opt_reg <= wb_dat_i[1:0];
			if (hit(adr, swm_pkg::ADDR_MASK))
				mask_reg <= wb_dat_i[swm_pkg::ST_W-1:0];
		end
	end

	// ----------------------------------------
	// Slave resume detect
	// ----------------------------------------
	// Line idles low while suspended; the slave resumes by pulling it high
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pinSync1_reg <= 1'b0;
			pinSync2_reg <= 1'b0;
			pinPrev_reg <= 1'b0;
		end else begin
			pinSync1_reg <= linkPin_i;
			pinSync2_reg <= pinSync1_reg;
			pinPrev_reg <= pinSync2_reg;
		end
	end

	// ----------------------------------------
	// Link sequencer
	// ----------------------------------------
	swm_bit_timer #(.DIV(swm_pkg::BIT_CYC)) u_timer (
		.mclk(mclk),
		.rst_n(rst_n),
		.run(state_reg != swm_pkg::SWM_OFF && state_reg != swm_pkg::SWM_SUSPENDED_STATUS_FLAG),
		.tick(tick)
	);

	always_comb begin
		evt = '0;
		if (ctrl_reg) begin
			case (state_reg)
				swm_pkg::SWM_IDLE: begin
					// Loop case goes back to RAISE without firing activation, never suspend
					if (tick && bitCnt_reg == 5'(swm_pkg::IDLE_BITS - 1)) begin
						evt.slave_resume_flag = !opt_reg[swm_pkg::OPT_CLKSEL];
						evt.suspended_status_flag = 1'b1;
					end
				end
				swm_pkg::SWM_SUSPENDED_STATUS_FLAG: begin
					// Oscillator clock loses the flag but still resumes
					if (pinSync2_reg && !pinPrev_reg) begin
						evt.act = 1'b1;
						evt.slave_resume_flag = !opt_reg[swm_pkg::OPT_CLKSEL];
					end
				end
				default: ;
			endcase
		end else if (state_reg != swm_pkg::SWM_OFF) begin
			evt.deact = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_reg <= swm_pkg::SWM_OFF;
			bitCnt_reg <= 5'h00;
		end else if (!ctrl_reg) begin
			state_reg <= swm_pkg::SWM_OFF;
			bitCnt_reg <= 5'h00;
		end else begin
			case (state_reg)
				swm_pkg::SWM_OFF: begin
					state_reg <= swm_pkg::SWM_RAISE;
					bitCnt_reg <= 5'h00;
				end
				swm_pkg::SWM_RAISE: begin
					if (tick)
						state_reg <= swm_pkg::SWM_TRANS;
				end
				swm_pkg::SWM_TRANS: begin
					if (tick) begin
						if (bitCnt_reg == 5'(swm_pkg::TRANS_BITS - 1)) begin
							state_reg <= swm_pkg::SWM_IDLE;
							bitCnt_reg <= 5'h00;
						end else begin
							bitCnt_reg <= bitCnt_reg + 5'h01;
						end
					end
				end
				swm_pkg::SWM_IDLE: begin
					if (tick) begin
						if (bitCnt_reg == 5'(swm_pkg::IDLE_BITS - 1)) begin
							bitCnt_reg <= 5'h00;
							if (opt_reg[swm_pkg::OPT_CLKSEL])
								state_reg <= swm_pkg::SWM_RAISE;
							else
								state_reg <= swm_pkg::SWM_SUSPENDED_STATUS_FLAG;
						end else begin
							bitCnt_reg <= bitCnt_reg + 5'h01;
						end
					end
				end
				swm_pkg::SWM_SUSPENDED_STATUS_FLAG: begin
					if (evt.act)
						state_reg <= swm_pkg::SWM_RAISE;
				end
				default: state_reg <= swm_pkg::SWM_OFF;
			endcase
		end
	end

	// ----------------------------------------
	// Status and interrupt
	// ----------------------------------------
	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			stat_reg <= '0;
		end else begin
			for (int i = 0; i < swm_pkg::ST_W; i++) begin
				if (wr && hit(adr, swm_pkg::ADDR_STAT) && wb_dat_i[i])
					stat_reg[i] <= 1'b0;
			end
			if (evt.slave_resume_flag)
				stat_reg[swm_pkg::ST_SRF] <= 1'b1;
			if (evt.act)
				stat_reg[swm_pkg::ST_ACT] <= 1'b1;
			if (evt.deact)
				stat_reg[swm_pkg::ST_DEACT] <= 1'b1;
			if (evt.suspended_status_flag)
				stat_reg[swm_pkg::ST_SUSPENDED_STATUS_FLAG] <= 1'b0;
		end
	end

	// ----------------------------------------
	// Pins
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			irq <= 1'b0;
			linkPin_o <= 1'b0;
			linkPin_oe <= 1'b0;
			bypassRx_o <= 1'b0;
			bypassRx_oe <= 1'b0;
			stopBlock <= 1'b0;
		end else begin
			irq <= |(stat_reg & mask_reg);
			// Line driven high through the pattern except the second TRANS bit, which is low; released when off
			linkPin_o <= state_reg == swm_pkg::SWM_RAISE ||
				state_reg == swm_pkg::SWM_IDLE ||
				(state_reg == swm_pkg::SWM_TRANS && !bitCnt_reg[0]);
			linkPin_oe <= ctrl_reg && state_reg != swm_pkg::SWM_OFF &&
				state_reg != swm_pkg::SWM_SUSPENDED_STATUS_FLAG;
			// Defect kept: bypass drives the receive pin instead of sensing it
			bypassRx_oe <= opt_reg[swm_pkg::OPT_BYPASS];
			bypassRx_o <= 1'b0;
			stopBlock <= state_reg == swm_pkg::SWM_SUSPENDED_STATUS_FLAG;
		end
	end
endmodule : swm_master

//--- logic/swm_pkg.sv
package swm_pkg;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STAT = 4'h4;
	localparam logic [3:0] ADDR_MASK = 4'h8;
	localparam logic [3:0] ADDR_OPT = 4'hc;
	// Control bits
	localparam int CTRL_EN = 0;
	localparam int CTRL_DEACT = 1;
	// Option bits
	localparam int OPT_CLKSEL = 0;
	localparam int OPT_BYPASS = 1;
	// Status / mask bits
	localparam int ST_SRF = 0;
	localparam int ST_SUSPENDED_STATUS_FLAG = 1;
	localparam int ST_ACT = 2;
	localparam int ST_DEACT = 3;
	localparam int ST_W = 4;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int LINK_MAX_MHZ = 8;
	localparam int BIT_CYC = (CLK_MHZ + LINK_MAX_MHZ - 1) / LINK_MAX_MHZ;
	localparam int IDLE_BITS = 14;
	localparam int TRANS_BITS = 2;
	localparam int RESUME_BITS = 2;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [4:0] {
		SWM_OFF = 5'h01,
		SWM_RAISE = 5'h02,
		SWM_TRANS = 5'h04,
		SWM_IDLE = 5'h08,
		SWM_SUSPENDED_STATUS_FLAG = 5'h10
	} swm_state_t;
	typedef struct packed {
		logic slave_resume_flag;
		logic suspended_status_flag;
		logic act;
		logic deact;
	} swm_evt_t;
endpackage : swm_pkg

//--- verification/swm_card.sv
`timescale 1ns/100ps
module swm_card (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic wake,
	input wire logic pinO,
	input wire logic pinOe,
	output logic pinI
);
	// ----
	// Card side
	// ----
	logic [7:0] cnt;
	always_ff @(posedge mclk) begin
		if (!rst_n)
			cnt <= 8'h0;
		else if (wake)
			cnt <= 8'(swm_pkg::RESUME_BITS * swm_pkg::BIT_CYC);
		else if (cnt != 8'h0)
			cnt <= cnt - 8'h1;
	end
	// Released line falls to the pull-down, not the last value
	assign pinI = pinOe ? pinO : (cnt != 8'h0);
endmodule : swm_card

//--- verification/swm_master_sva.sv
`timescale 1ns/100ps
module swm_master_sva (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic linkPin_i,
	input wire logic linkPin_o,
	input wire logic linkPin_oe,
	input wire logic bypassRx_o,
	input wire logic stopBlock
);
	// ----
	// Checks
	// ----
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire offWr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
		wb_adr_i == 32'(swm_pkg::ADDR_CTRL) && !wb_dat_i[0];
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	a_bypass_low: assert property (!bypassRx_o)
		else $error("bypass pin driven high");
	a_suspended_status_flag_released: assert property (stopBlock |-> !linkPin_oe)
		else $error("line driven while suspended");
	a_suspended_status_flag_entry: assert property ($rose(stopBlock) |-> $past(linkPin_oe))
		else $error("suspend without sequence");
	a_raise_hold: assert property ($rose(linkPin_oe) |-> (linkPin_oe && linkPin_o)[*8])
		else $error("raise not high");
	a_off_release: assert property (offWr |-> ##[1:3] !linkPin_oe && !stopBlock)
		else $error("line kept after disable");
	// Bound covers sync flops, edge detect and registered output
	a_wake_bound: assert property (stopBlock && $rose(linkPin_i) |-> ##[1:8] !stopBlock)
		else $error("resume ignored");
	cover property ($rose(stopBlock));
	cover property ($fell(stopBlock));
	cover property (offWr);
endmodule : swm_master_sva

//--- verification/swm_master_tb.sv
`timescale 1ns/100ps
module swm_master_tb;
	localparam logic [31:0] CT = 32'(swm_pkg::ADDR_CTRL);
	localparam logic [31:0] ST = 32'(swm_pkg::ADDR_STAT);
	localparam logic [31:0] MK = 32'(swm_pkg::ADDR_MASK);
	localparam logic [31:0] OP = 32'(swm_pkg::ADDR_OPT);
	logic mclk, rst_n, we, cyc, stb, ack, irq, wake;
	logic pI, pO, pOe, bO, bOe, stopB;
	logic [31:0] adr, wdat, rdat, q;
	logic [3:0] sel;
	int error_cnt, checks, n, lo, k;
	swm_master swm_master_i (.mclk(mclk), .rst_n(rst_n), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_sel_i(sel), .wb_we_i(we),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .irq(irq),
		.linkPin_i(pI), .linkPin_o(pO), .linkPin_oe(pOe),
		.bypassRx_i(1'h0), .bypassRx_o(bO), .bypassRx_oe(bOe),
		.stopBlock(stopB));
	swm_card swm_card_i (.mclk(mclk), .rst_n(rst_n), .wake(wake),
		.pinO(pO), .pinOe(pOe), .pinI(pI));
	// ----
	// Tasks
	// ----
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] d);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge mclk); while (ack !== 1'h1);
		q = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		@(posedge mclk);
	endtask : xfer
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		xfer(1'h0, a, 32'h0);
		chk("read", e, q);
	endtask : rd
	task end_of_test;
		if (error_cnt == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	// ----
	// Tests
	// ----
	initial begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end
	always @(negedge mclk) begin
		n += (pOe === 1'h1);
		lo += (pOe === 1'h1 && pO === 1'h0);
	end
	initial begin
		{rst_n, we, cyc, stb, wake} = 5'h0;
		adr = 32'h0;
		wdat = 32'h0;
		sel = 4'hf;
		repeat (5) @(posedge mclk);
		rst_n <= 1'h1;
		for (int i = 0; i < 5; i++) rd(32'(i * 4), 32'h0);
		xfer(1'h1, 32'h10, 32'hf);
		rd(32'h10, 32'h0);
		rd(OP, 32'h0);
		xfer(1'h1, MK, 32'h1);
		n = 0;
		lo = 0;
		xfer(1'h1, CT, 32'h1);
		for (k = 0; k < 2000 && stopB !== 1'h1; k++) @(posedge mclk);
		chk("drive", 32'((1 + swm_pkg::TRANS_BITS + swm_pkg::IDLE_BITS)
			* swm_pkg::BIT_CYC), 32'(n));
		chk("low", 32'(swm_pkg::BIT_CYC), 32'(lo));
		chk("stop", 32'h1, {31'h0, stopB});
		chk("irq", 32'h1, {31'h0, irq});
		rd(ST, 32'h1);
		xfer(1'h1, MK, 32'h0);
		xfer(1'h1, ST, 32'hf);
		rd(ST, 32'h0);
		wake <= 1'h1;
		@(posedge mclk);
		wake <= 1'h0;
		repeat (20) @(posedge mclk);
		chk("stop", 32'h0, {31'h0, stopB});
		rd(ST, 32'h5);
		chk("irq", 32'h0, {31'h0, irq});
		xfer(1'h1, MK, 32'h4);
		@(posedge mclk);
		chk("irq", 32'h1, {31'h0, irq});
		xfer(1'h1, CT, 32'h0);
		rd(ST, 32'hd);
		chk("oe", 32'h0, {31'h0, pOe});
		xfer(1'h1, ST, 32'hf);
		xfer(1'h1, OP, 32'h1);
		lo = 0;
		xfer(1'h1, CT, 32'h1);
		repeat (600) @(posedge mclk);
		chk("stop", 32'h0, {31'h0, stopB});
		chk("loop", 32'(3 * swm_pkg::BIT_CYC), 32'(lo));
		rd(ST, 32'h0);
		xfer(1'h1, CT, 32'h0);
		xfer(1'h1, OP, 32'h2);
		rd(OP, 32'h2);
		chk("bypass", 32'h2, {30'h0, bOe, bO});
		end_of_test;
	end
	initial begin
		repeat (5000) @(posedge mclk);
		error_cnt++;
		end_of_test;
	end
endmodule : swm_master_tb
bind swm_master swm_master_sva swm_master_sva_i (.mclk(mclk), .rst_n(rst_n),
	.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.linkPin_i(linkPin_i), .linkPin_o(linkPin_o), .linkPin_oe(linkPin_oe),
	.bypassRx_o(bypassRx_o), .stopBlock(stopBlock));
